// *** shared/spi_eeprom_defines.svh ***
// Named constants of the serial EEPROM command and status logic.
// Assumes inclusion by bare name from spi_eeprom_core.
`ifndef SPI_EEPROM_DEFINES_SVH
`define SPI_EEPROM_DEFINES_SVH

// Opcode layout: upper nibble fixed, bit 3 carries address bit 8, low three select
`define OPC_HI         4'h0
`define OPC_A8_BIT     3
`define OPC_SET_WRITE_LATCH       3'h6
`define OPC_CLEAR_WRITE_LATCH       3'h4
`define OPC_STATUS_READ_COMMAND       3'h5
`define OPC_STATUS_WRITE_COMMAND       3'h1
`define OPC_READ       3'h3
`define OPC_WRITE      3'h2

// Status register layout
`define ST_FILL        4'hf
`define ST_BP_HI       3
`define ST_BP_LO       2

// Frame counting: bit index of the last bit in a byte, byte counts per command
`define BIT_FIRST      3'h0
`define BIT_LAST       3'h7
`define BYTES_NONE     2'h0
`define BYTES_LATCH    2'h1
`define BYTES_STATUS   2'h2
`define BYTES_WRITE    2'h3

// Block protect encodings
`define BP_NONE        2'h0
`define BP_QUARTER     2'h1
`define BP_HALF        2'h2
`define BP_ALL         2'h3

// Page geometry and array contents
`define PAGE_BYTES     16
`define COL_W          4
`define MEM_ERASED     8'hff

// Program cycle time and clock period, both in ns
`define PROG_TIME_NS   4000000
`define CLK_PERIOD_NS  10

`endif

// *** shared/spi_eeprom_pkg.sv ***
// Types shared by the serial EEPROM command and status logic.
// Assumes the defines header is on the include path.
package spi_eeprom_pkg;

   // Pins seen from the host side, after synchronisation
   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic wp_n;
   } pins_t;

   // Frame sequencer states, one-hot
   typedef enum logic [7:0] {
      ST_IDLE   = 8'h01,
      ST_OPCODE = 8'h02,
      ST_ADDR   = 8'h04,
      ST_RDATA  = 8'h08,
      ST_WDATA  = 8'h10,
      ST_SREAD  = 8'h20,
      ST_SWRITE = 8'h40,
      ST_LATCH  = 8'h80
   } state_t;

   // Decoded command held for the rest of the frame
   typedef enum logic [2:0] {
      CMD_NONE, CMD_SET_WRITE_LATCH, CMD_CLEAR_WRITE_LATCH, CMD_STATUS_READ_COMMAND, CMD_STATUS_WRITE_COMMAND, CMD_READ, CMD_WRITE
   } cmd_t;

endpackage : spi_eeprom_pkg

// *** src/spi_pin_sync.sv ***
// Two-stage synchroniser with edge detection for a group of pins.
// Assumes the pins are asynchronous to I_CLK and change slower than it.
`timescale 1ns/100ps
module spi_pin_sync #(
   parameter int W = 4
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   // Raw pins
   input  wire logic [W-1:0] i_pins,
   // Synchronised level and one-cycle edge pulses
   output logic      [W-1:0] o_level,
   output logic      [W-1:0] o_rise,
   output logic      [W-1:0] o_fall
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;
   logic [W-1:0] prev_reg;

   // First stage feeds only the second; edges compare stages two and three
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         meta_reg <= '1;
         sync_reg <= '1;
         prev_reg <= '1;
      end else begin
         meta_reg <= i_pins;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // Edge pulses
   assign o_level = sync_reg;
   assign o_rise  = sync_reg & ~prev_reg;
   assign o_fall  = ~sync_reg & prev_reg;

endmodule : spi_pin_sync

// *** src/spi_eeprom_core.sv ***
// Command, status and array logic of a small SPI serial EEPROM.
// Assumes SCK well below I_CLK/4 so every SCK edge is seen; pins are asynchronous.
`timescale 1ns/100ps
`include "spi_eeprom_defines.svh"
module spi_eeprom_core
   import spi_eeprom_pkg::*;
#(
   parameter int ADDR_W      = 9,
   parameter int PROG_CYCLES = `PROG_TIME_NS / `CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire logic I_CLK,
   input  wire logic I_RST_N,
   // Serial link from the host
   input  wire logic I_CS_N,
   input  wire logic I_SCK,
   input  wire logic I_SI,
   input  wire logic I_WP_N,
   // Serial data out, three-state
   output logic      O_SO,
   output logic      O_SO_OE
);
   localparam int DEPTH = 1 << ADDR_W;
   localparam int CNT_W = $clog2(PROG_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PROG_CYCLES - 1);

   // Only 7 to 9 address bits fit the opcode and address byte format
   if (ADDR_W < 7 || ADDR_W > 9 || PROG_CYCLES < 1) begin : g_bad_param
      $error("spi_eeprom_core: unsupported ADDR_W or PROG_CYCLES");
   end

   // Address from opcode bit and address byte, narrowed to the array
   function automatic logic [ADDR_W-1:0] addr_of(input logic a8, input logic [7:0] lo);
      logic [8:0] full;
      full = {a8, lo};
      return full[ADDR_W-1:0];
   endfunction : addr_of

   // Protected region is the top quarter, top half or whole array
   function automatic logic is_prot(input logic [1:0] bp, input logic [1:0] top);
      return (bp == `BP_ALL) || (bp == `BP_HALF && top[1]) ||
             (bp == `BP_QUARTER && top == 2'h3);
   endfunction : is_prot

   pins_t pin_lv;
   pins_t pin_rs;
   pins_t pin_fl;

   state_t              state_reg;
   cmd_t                cmd_reg;
   logic [7:0]          sh_reg;
   logic [2:0]          bit_reg;
   logic [1:0]          byte_reg;
   logic                a8_reg;
   logic [ADDR_W-1:0]   addr_reg;
   logic [1:0]          bp_new_reg;
   logic [1:0]          bp_reg;
   logic                wel_reg;
   logic                busy_reg;
   logic                kind_mem_reg;
   logic [CNT_W-1:0]    cnt_reg;
   logic [7:0]          page_buf [`PAGE_BYTES];
   logic [`PAGE_BYTES-1:0] mask_reg;
   logic [`COL_W-1:0]   col_reg;
   logic [7:0]          mem [DEPTH];
   logic [7:0]          out_byte_reg;
   logic [2:0]          out_bit_reg;
   logic [ADDR_W-1:0]   rd_addr_reg;
   logic                so_reg;
   logic                so_oe_reg;

   logic                sel;
   logic                cs_rise;
   logic                cs_fall;
   logic                sck_rise;
   logic                sck_fall;
   logic [7:0]          byte_in;
   logic                byte_done;
   logic                whole;
   logic [ADDR_W-1:0]   new_addr;
   logic [7:0]          status;
   logic                latch_ok;
   logic                status_write_command_go;
   logic                write_go;
   logic                prog_done;
   logic                load_stat;
   logic                load_read;

   // Link pins reach logic only after two flip-flops
   spi_pin_sync #(
      .W       ($bits(pins_t))
   ) u_sync (
      .i_clk   (I_CLK),
      .i_rst_n (I_RST_N),
      .i_pins  ({I_CS_N, I_SCK, I_SI, I_WP_N}),
      .o_level (pin_lv),
      .o_rise  (pin_rs),
      .o_fall  (pin_fl)
   );

   // Frame events and cancellation checks at deselect
   always_comb begin
      sel       = !pin_lv.cs_n;
      cs_rise   = pin_rs.cs_n;
      cs_fall   = pin_fl.cs_n;
      sck_rise  = pin_rs.sck && sel;
      sck_fall  = pin_fl.sck && sel;
      byte_in   = {sh_reg[6:0], pin_lv.si};
      byte_done = sck_rise && (bit_reg == `BIT_LAST);
      whole     = (bit_reg == `BIT_FIRST);
      new_addr  = addr_of(a8_reg, byte_in);
      status    = {`ST_FILL, bp_reg, wel_reg, busy_reg};
      latch_ok  = cs_rise && state_reg == ST_LATCH && byte_reg == `BYTES_LATCH && whole;
      status_write_command_go   = cs_rise && state_reg == ST_SWRITE && byte_reg == `BYTES_STATUS && whole
                  && pin_lv.wp_n;
      write_go  = cs_rise && state_reg == ST_WDATA && byte_reg == `BYTES_WRITE && whole
                  && (|mask_reg) && pin_lv.wp_n && wel_reg;
      prog_done = busy_reg && (cnt_reg == CNT_LAST);
      load_stat = byte_done && state_reg == ST_OPCODE && byte_in[7:4] == `OPC_HI
                  && byte_in[2:0] == `OPC_STATUS_READ_COMMAND;
      load_read = byte_done && state_reg == ST_ADDR && cmd_reg == CMD_READ;
   end

   // Bit and byte counters; byte count saturates past the longest fixed frame
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         sh_reg   <= 8'h00;
         bit_reg  <= `BIT_FIRST;
         byte_reg <= `BYTES_NONE;
      end else if (cs_fall) begin
         bit_reg  <= `BIT_FIRST;
         byte_reg <= `BYTES_NONE;
      end else if (sck_rise) begin
         sh_reg  <= byte_in;
         bit_reg <= bit_reg + 3'h1;
         if (bit_reg == `BIT_LAST && byte_reg != `BYTES_WRITE) begin
            byte_reg <= byte_reg + 2'h1;
         end
      end
   end

   // Frame sequencer: opcode decode, acceptance checks and address capture
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         state_reg  <= ST_IDLE;
         cmd_reg    <= CMD_NONE;
         a8_reg     <= 1'b0;
         addr_reg   <= '0;
         bp_new_reg <= `BP_NONE;
      end else if (cs_rise) begin
         state_reg <= ST_IDLE;
      end else if (cs_fall) begin
         state_reg <= ST_OPCODE;
         cmd_reg   <= CMD_NONE;
      end else if (byte_done) begin
         case (state_reg)
            ST_OPCODE: begin
               a8_reg    <= byte_in[`OPC_A8_BIT];
               state_reg <= ST_LATCH;
               if (byte_in[7:4] != `OPC_HI) begin
                  state_reg <= ST_IDLE;
               end else begin
                  case (byte_in[2:0])
                     `OPC_SET_WRITE_LATCH: cmd_reg <= CMD_SET_WRITE_LATCH;
                     `OPC_CLEAR_WRITE_LATCH: cmd_reg <= CMD_CLEAR_WRITE_LATCH;
                     `OPC_STATUS_READ_COMMAND: begin
                        cmd_reg   <= CMD_STATUS_READ_COMMAND;
                        state_reg <= ST_SREAD;
                     end
                     `OPC_STATUS_WRITE_COMMAND: begin
                        cmd_reg   <= CMD_STATUS_WRITE_COMMAND;
                        state_reg <= (wel_reg && pin_lv.wp_n && !busy_reg) ?
                                     ST_SWRITE : ST_IDLE;
                     end
                     `OPC_READ: begin
                        cmd_reg   <= CMD_READ;
                        state_reg <= busy_reg ? ST_IDLE : ST_ADDR;
                     end
                     `OPC_WRITE: begin
                        cmd_reg   <= CMD_WRITE;
                        state_reg <= (wel_reg && pin_lv.wp_n && !busy_reg) ?
                                     ST_ADDR : ST_IDLE;
                     end
                     default: state_reg <= ST_IDLE;
                  endcase
               end
            end
            ST_ADDR: begin
               addr_reg <= new_addr;
               if (cmd_reg == CMD_READ) begin
                  state_reg <= ST_RDATA;
               end else if (is_prot(bp_reg, new_addr[ADDR_W-1 -: 2])) begin
                  state_reg <= ST_IDLE;
               end else begin
                  state_reg <= ST_WDATA;
               end
            end
            ST_SWRITE: bp_new_reg <= byte_in[`ST_BP_HI:`ST_BP_LO];
            default: state_reg <= state_reg;
         endcase
      end
   end

   // Page buffer: low address bits wrap, upper bits stay fixed
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         mask_reg <= '0;
         col_reg  <= '0;
         for (int i = 0; i < `PAGE_BYTES; i++) begin
            page_buf[i] <= 8'h00;
         end
      end else if (byte_done && state_reg == ST_ADDR) begin
         mask_reg <= '0;
         col_reg  <= new_addr[`COL_W-1:0];
      end else if (byte_done && state_reg == ST_WDATA) begin
         page_buf[col_reg] <= byte_in;
         mask_reg[col_reg] <= 1'b1;
         col_reg           <= col_reg + 4'h1;
      end
   end

   // Program cycle timer; a new cycle cannot start while busy
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         busy_reg     <= 1'b0;
         kind_mem_reg <= 1'b0;
         cnt_reg      <= '0;
      end else if (!busy_reg && (status_write_command_go || write_go)) begin
         busy_reg     <= 1'b1;
         kind_mem_reg <= write_go;
         cnt_reg      <= '0;
      end else if (prog_done) begin
         busy_reg <= 1'b0;
      end else if (busy_reg) begin
         cnt_reg <= cnt_reg + CNT_W'(1);
      end
   end

   // Write latch; guard pin low wins, a set beats a simultaneous completion clear
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         wel_reg <= 1'b0;
      end else if (!pin_lv.wp_n) begin
         wel_reg <= 1'b0;
      end else if (latch_ok && cmd_reg == CMD_SET_WRITE_LATCH) begin
         wel_reg <= 1'b1;
      end else if ((latch_ok && cmd_reg == CMD_CLEAR_WRITE_LATCH) || prog_done) begin
         wel_reg <= 1'b0;
      end
   end

   // Protect bits change only when their program cycle ends
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         bp_reg <= `BP_NONE;
      end else if (prog_done && !kind_mem_reg) begin
         bp_reg <= bp_new_reg;
      end
   end

   // Array, reset to the erased value; written only at program completion
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= `MEM_ERASED;
         end
      end else if (prog_done && kind_mem_reg) begin
         for (int i = 0; i < `PAGE_BYTES; i++) begin
            if (mask_reg[i]) begin
               mem[{addr_reg[ADDR_W-1:`COL_W], `COL_W'(i)}] <= page_buf[i];
            end
         end
      end
   end

   // Output shifter: first byte loaded on a rising edge, later bytes reloaded and bits leave on falling edges
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         out_byte_reg <= 8'h00;
         out_bit_reg  <= `BIT_FIRST;
         rd_addr_reg  <= '0;
         so_reg       <= 1'b0;
      end else if (load_stat) begin
         out_byte_reg <= status;
         out_bit_reg  <= `BIT_FIRST;
      end else if (load_read) begin
         out_byte_reg <= mem[new_addr];
         rd_addr_reg  <= new_addr;
         out_bit_reg  <= `BIT_FIRST;
      end else if (sck_fall && (state_reg == ST_SREAD || state_reg == ST_RDATA)) begin
         so_reg      <= out_byte_reg[~out_bit_reg];
         out_bit_reg <= out_bit_reg + 3'h1;
         if (out_bit_reg == `BIT_LAST && state_reg == ST_SREAD) begin
            out_byte_reg <= status;
         end else if (out_bit_reg == `BIT_LAST) begin
            out_byte_reg <= mem[rd_addr_reg + ADDR_W'(1)];
            rd_addr_reg  <= rd_addr_reg + ADDR_W'(1);
         end
      end
   end

   // Drive SO only while a read is streaming; released on deselect
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         so_oe_reg <= 1'b0;
      end else begin
         so_oe_reg <= sel && !cs_rise && (state_reg == ST_SREAD || state_reg == ST_RDATA);
      end
   end

   assign O_SO    = so_reg;
   assign O_SO_OE = so_oe_reg;

endmodule : spi_eeprom_core

// *** tb/spi_eeprom_core_sva.sv ***
// Port-level checker for the serial EEPROM command and status logic.
// Assumes SCK levels last several I_CLK cycles and CS_N idles high at least three.
`timescale 1ns/100ps
module spi_eeprom_core_sva (
   // Clock and reset
   input  wire logic I_CLK,
   input  wire logic I_RST_N,
   // Link pins
   input  wire logic I_CS_N,
   input  wire logic I_SCK,
   input  wire logic I_SI,
   input  wire logic I_WP_N,
   input  wire logic O_SO,
   input  wire logic O_SO_OE
);
   logic        sck_q;
   logic [15:0] rise_cnt;
   logic [7:0]  op;
   wire         sck_rise = I_SCK && !sck_q;
   wire         is_status_read_command  = (op[7:4] == 4'h0) && (op[2:0] == 3'h5);
   wire         is_read  = (op[7:4] == 4'h0) && (op[2:0] == 3'h3);

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);

   // Raw SCK edge seen two clocks ahead of the design's synchroniser
   always_ff @(posedge I_CLK) begin
      sck_q <= I_RST_N ? I_SCK : 1'b0;
   end
   // Rising SCK count within the current frame
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N || I_CS_N) begin
         rise_cnt <= 16'h0000;
      end else if (sck_rise) begin
         rise_cnt <= rise_cnt + 16'h0001;
      end
   end
   // Opcode captured from the first eight bits
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         op <= 8'h00;
      end else if (!I_CS_N && sck_rise && rise_cnt < 16'h0008) begin
         op <= {op[6:0], I_SI};
      end
   end

   AST_RESET_QUIET: assert property ($rose(I_RST_N) |-> !O_SO_OE && !O_SO)
      else $error("output active right after reset");
   AST_OE_OFF_DESEL: assert property (I_CS_N [*5] |-> !O_SO_OE)
      else $error("output enable held after deselect");
   AST_OE_HOLD: assert property ((!I_CS_N) [*4] ##0 O_SO_OE |=> O_SO_OE)
      else $error("output enable dropped while selected");
   AST_OE_ROSE_POINT: assert property ($rose(O_SO_OE) |-> !I_CS_N &&
      ((rise_cnt == 16'h0008 && is_status_read_command) || (rise_cnt == 16'h0010 && is_read)))
      else $error("output enable rose at wrong clock count");
   AST_OE_VALID_OP: assert property (O_SO_OE && !I_CS_N && rise_cnt >= 16'h0008
      |-> is_status_read_command || is_read)
      else $error("output driven for a non-read opcode");
   AST_NO_OE_IN_OPCODE: assert property (!I_CS_N && rise_cnt < 16'h0008 |-> !O_SO_OE)
      else $error("output driven during opcode");
   AST_STATUS_ONES: assert property (!I_CS_N && sck_rise && is_status_read_command &&
      rise_cnt >= 16'h0008 && !rise_cnt[2] |-> O_SO)
      else $error("status upper nibble not one");
   AST_SO_EDGE: assert property ($changed(O_SO) && O_SO_OE && $past(O_SO_OE)
      |-> !$past(I_SCK, 2))
      else $error("serial output changed outside SCK low phase");

   // Main scenarios reached
   cover property ($rose(O_SO_OE) && is_status_read_command);
   cover property ($rose(O_SO_OE) && is_read);
   cover property ($fell(O_SO_OE));
endmodule : spi_eeprom_core_sva

bind spi_eeprom_core spi_eeprom_core_sva u_sva (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
   .I_CS_N(I_CS_N), .I_SCK(I_SCK), .I_SI(I_SI), .I_WP_N(I_WP_N), .O_SO(O_SO),
   .O_SO_OE(O_SO_OE));

// *** tb/spi_host_model.sv ***
// Behavioural SPI host (mode 0) for the serial EEPROM.
// Assumes a 100 MHz clock; SCK 130 ns, changed only at falling clock edges.
`timescale 1ns/100ps
module spi_host_model (
   // Clock
   input  wire logic       i_clk,
   // Device answer
   input  wire logic       i_so,
   input  wire logic       i_so_oe,
   // Host drive
   output logic            o_cs_n,
   output logic            o_sck,
   output logic            o_si,
   output logic [7:0]      o_rx
);
   event rx_done;

   // Idle: deselected, SCK parked low
   initial begin
      o_cs_n = 1'b1;
      o_sck  = 1'b0;
      o_si   = 1'b0;
      o_rx   = 8'h00;
   end

   // Open a frame
   task automatic sel();
      @(negedge i_clk) o_cs_n = 1'b0;
      repeat (3) @(negedge i_clk);
   endtask : sel

   // Close right after the last fall, so the clock count is exact
   task automatic desel();
      @(negedge i_clk) o_cs_n = 1'b1;
      o_si = ~o_si; // Released line must not keep its last value
      repeat (6) @(negedge i_clk);
   endtask : desel

   // Shift n bits MSB first; SO taken at each rise, byte reported if output enabled
   task automatic shift(input logic [7:0] tx, input int n);
      logic oe;
      oe = i_so_oe;
      for (int i = 0; i < n; i++) begin
         o_si = tx[7 - (i % 8)];
         repeat (7) @(negedge i_clk);
         o_sck = 1'b1;
         o_rx  = {o_rx[6:0], i_so};
         repeat (6) @(negedge i_clk);
         o_sck = 1'b0;
      end
      if (oe) begin
         -> rx_done;
      end
   endtask : shift
endmodule : spi_host_model

// *** tb/spi_eeprom_command_status_logic_tb.sv ***
// Self-checking bench for the serial EEPROM command and status logic.
// Assumes the host model in tb/ and a shortened program cycle.
`timescale 1ns/100ps
module spi_eeprom_command_status_logic_tb import spi_eeprom_pkg::*; ;
   // Long enough that two status bytes and a refused read fit inside one program cycle
   localparam int PROG = 1000;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       wp_n = 1'b1;
   logic       cs_n, sck, si, so, so_oe;
   logic [7:0] rx;
   logic [7:0] mem [512];
   logic [7:0] exp_q [$];
   logic [8:0] addr;
   int         error_cnt = 0;
   int         total_checks = 0;
   integer     seed = 32'h82ca5fd8;

   // 100 MHz clock
   always #5 clk = ~clk;

   spi_eeprom_core #(.PROG_CYCLES(PROG)) dut (.I_CLK(clk), .I_RST_N(rst_n), .I_CS_N(cs_n),
      .I_SCK(sck), .I_SI(si), .I_WP_N(wp_n), .O_SO(so), .O_SO_OE(so_oe));
   spi_host_model host (.i_clk(clk), .i_so(so), .i_so_oe(so_oe), .o_cs_n(cs_n),
      .o_sck(sck), .o_si(si), .o_rx(rx));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t read byte %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Every byte the device streams is matched against the oldest note
   initial forever begin
      @(host.rx_done);
      if (exp_q.size() == 0) begin
         error_cnt++;
         $display("MISMATCH t=%0t unexpected read byte %h", $time, rx);
      end else begin
         chk(rx, exp_q.pop_front());
      end
   end

   task automatic summarize();
      if (exp_q.size() != 0) begin
         error_cnt++;
         $display("MISMATCH t=%0t %0d bytes never returned", $time, exp_q.size());
      end
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize

   // Short command frame with a chosen clock count
   task automatic cmd(input logic [7:0] op, input int nbits);
      host.sel();
      host.shift(op, nbits);
      host.desel();
   endtask : cmd

   task automatic status_read_command(input logic [7:0] e, input int n);
      host.sel();
      host.shift(8'h05, 8);
      repeat (n) begin
         exp_q.push_back(e);
         host.shift(8'h00, 8);
      end
      host.desel();
   endtask : status_read_command

   task automatic status_write_command(input logic [7:0] d, input int xb);
      host.sel();
      host.shift(8'h01, 8);
      host.shift(d, 8);
      if (xb > 0) host.shift(8'h00, xb);
      host.desel();
   endtask : status_write_command

   // Memory read; ok=0 means the device must stay silent
   task automatic rd(input logic [8:0] a, input int n, input bit ok);
      host.sel();
      host.shift({4'h0, a[8], 3'h3}, 8);
      host.shift(a[7:0], 8);
      for (int i = 0; i < n; i++) begin
         if (ok) exp_q.push_back(mem[9'(a + i)]);
         host.shift(8'h00, 8);
      end
      host.desel();
   endtask : rd

   // Page write of random bytes; xb extra clocks cancel it
   task automatic wr(input logic [8:0] a, input int n, input bit ok, input int xb);
      logic [7:0] d;
      host.sel();
      host.shift({4'h0, a[8], 3'h2}, 8);
      host.shift(a[7:0], 8);
      for (int i = 0; i < n; i++) begin
         d = 8'($random(seed));
         if (ok && xb == 0) mem[{a[8:4], 4'(a[3:0] + i)}] = d;
         host.shift(d, 8);
      end
      if (xb > 0) host.shift(8'h5a, xb);
      host.desel();
   endtask : wr

   task automatic wait_prog();
      repeat (PROG + 20) @(negedge clk);
   endtask : wait_prog

   // Hang guard
   initial begin
      #900000;
      error_cnt++;
      $display("MISMATCH t=%0t run did not finish", $time);
      summarize();
   end

   // Main sequence
   initial begin
      for (int i = 0; i < 512; i++) mem[i] = 8'hff;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      status_read_command(8'hf0, 3);
      $display("test power-on status done");
      cmd(8'h06, 9); status_read_command(8'hf0, 1);
      cmd(8'h06, 8); status_read_command(8'hf2, 1);
      cmd(8'h04, 7); status_read_command(8'hf2, 1);
      cmd(8'h0c, 8); status_read_command(8'hf0, 1);
      $display("test write latch done");
      addr = 9'($random(seed));
      wr(addr, 1, 1'b0, 0); rd(addr, 1, 1'b1);
      cmd(8'h06, 8); wr(addr, 1, 1'b0, 3); status_read_command(8'hf2, 1);
      wr(addr, 18, 1'b1, 0); status_read_command(8'hf3, 2);
      rd(addr, 2, 1'b0);
      wait_prog();
      status_read_command(8'hf0, 1);
      rd({addr[8:4], 4'h0}, 16, 1'b1);
      rd(9'h1ff, 2, 1'b1);
      $display("test page write and read done");
      cmd(8'h06, 8); status_write_command(8'hff, 0); status_read_command(8'hf3, 1);
      wait_prog();
      status_read_command(8'hfc, 1);
      cmd(8'h06, 8); wr(addr, 1, 1'b0, 0); status_read_command(8'hfe, 1); rd(addr, 1, 1'b1);
      $display("test block protect done");
      @(negedge clk) wp_n = 1'b0;
      repeat (4) @(negedge clk);
      status_read_command(8'hfc, 1);
      cmd(8'h06, 8); status_write_command(8'h00, 0); wait_prog(); status_read_command(8'hfc, 1);
      @(negedge clk) wp_n = 1'b1;
      cmd(8'h06, 8); status_write_command(8'h00, 1); wait_prog(); status_read_command(8'hfe, 1);
      status_write_command(8'h00, 0); wait_prog(); status_read_command(8'hf0, 1);
      $display("test guard pin done");
      host.sel(); host.shift(8'h85, 8); host.shift(8'h00, 8); host.desel();
      status_read_command(8'hf0, 1);
      $display("test invalid opcode done");
      summarize();
   end
endmodule : spi_eeprom_command_status_logic_tb
